// ==== hw/psrg_pkg.sv ====
package psrg_pkg;
    // =====================================================================
    // command codes
    localparam logic [7:0] CMD_RISE_TIME = 8'h61;
    localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    // =====================================================================
    // rise-time word layout
    localparam int RISE_EXP_LSB = 11;
    localparam logic [4:0] RISE_EXP_VAL = 5'h1c;
    localparam logic [7:0] RISE_MANT_RST = 8'h2b;
    localparam int RISE_SETTINGS = 8;
    localparam logic [2:0] RISE_IDX_RST = 3'h4;
    // mantissa codes in 1/16 ms: 0.6,0.9,1.2,1.8,2.7,4.2,6.0,9.0 ms
    localparam logic [7:0] RISE_CODE [RISE_SETTINGS] = '{
        8'h0a, 8'h0e, 8'h13, 8'h1d, 8'h2b, 8'h43, 8'h60, 8'h90};
    // times in microseconds
    localparam int RISE_US [RISE_SETTINGS] = '{600, 900, 1200, 1800, 2700, 4200, 6000, 9000};
    localparam int CLK_MHZ = 200;
    // =====================================================================
    // summary byte bits
    localparam int SB_OFF = 6;
    localparam int SB_VOUT_OV = 5;
    localparam int SB_IOUT_OC = 4;
    localparam int SB_VIN_UV = 3;
    localparam int SB_TEMP = 2;
    localparam int SB_CML = 1;
    localparam int SB_OTHER = 0;
    // high byte bits of the summary word
    localparam int SW_VOUT = 7;
    localparam int SW_IOUT = 6;
    localparam int SW_MAKER = 4;
    localparam int SW_PGOOD = 3;
    localparam int PAGES = 2;
    // 16-bit reference steps over a full ramp
    localparam int REF_W = 16;
endpackage

// ==== hw/psrg_ramp_if.sv ====
`timescale 1ns/100ps
interface psrg_ramp_if;
    logic start;
    logic [2:0] idx;
    logic instant;
    logic [15:0] target;
    logic [15:0] ref_val;
    logic busy;
    modport ctl (output start, output idx, output instant, output target,
                 input ref_val, input busy);
    modport ramp (input start, input idx, input instant, input target,
                  output ref_val, output busy);
endinterface

// ==== hw/psrg_ramp.sv ====
`timescale 1ns/100ps
module psrg_ramp (
    input wire logic i_clk,
    input wire logic i_rst,
    psrg_ramp_if.ramp rp
);
    // =====================================================================
    // step period per setting: ramp time spread over 2^16 reference steps
    function automatic logic [15:0] step_cycles(input logic [2:0] idx);
        int c;
        c = (psrg_pkg::RISE_US[idx] * psrg_pkg::CLK_MHZ) >> psrg_pkg::REF_W;
        if (c < 1) begin
            c = 1;
        end
        return c[15:0];
    endfunction
    logic [15:0] div_r;
    logic [15:0] ref_r;
    logic busy_r;
    logic tick;
    assign tick = (div_r == 16'h0000);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            div_r <= 16'h0000;
        end else if (rp.start || tick) begin
            div_r <= step_cycles(rp.idx) - 16'h0001;
        end else begin
            div_r <= div_r - 16'h0001;
        end
    end
    // reference moves one step per tick so trims mid-ramp slew at the same rate
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ref_r <= 16'h0000;
            busy_r <= 1'b0;
        end else if (rp.start) begin
            busy_r <= !rp.instant;
            ref_r <= rp.instant ? rp.target : 16'h0000; // see RL4
        end else if (busy_r && tick) begin
            if (ref_r < rp.target) begin
                ref_r <= ref_r + 16'h0001; // see RL5
            end else if (ref_r > rp.target) begin
                ref_r <= ref_r - 16'h0001; // see RL5
            end else begin
                busy_r <= 1'b0;
            end
        end else if (!busy_r) begin
            ref_r <= rp.target;
        end
    end
    assign rp.ref_val = ref_r;
    assign rp.busy = busy_r;
    a_ramp_instant: assert property (@(posedge i_clk) disable iff (i_rst)
        rp.start && rp.instant |=> !busy_r && ref_r == $past(rp.target)) // see RL4
        else $error("zero rise time did not jump");
    a_ramp_step: assert property (@(posedge i_clk) disable iff (i_rst)
        busy_r && !rp.start |=> (ref_r - $past(ref_r) <= 16'h0001)
            || ($past(ref_r) - ref_r <= 16'h0001)) // see RL5
        else $error("reference jumped during ramp");
endmodule

// ==== hw/psrg_page_mem.sv ====
`timescale 1ns/100ps
module psrg_page_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_we,
    input wire logic [$clog2(DEPTH)-1:0] i_waddr,
    input wire logic [WIDTH-1:0] i_wdata,
    input wire logic [$clog2(DEPTH)-1:0] i_raddr,
    input wire logic [WIDTH-1:0] i_rst_val,
    output logic [WIDTH-1:0] o_rdata,
    output logic [WIDTH*DEPTH-1:0] o_all
);
    initial begin
        if (DEPTH < 2) begin
            $error("depth must be at least 2");
        end
    end
    logic [WIDTH-1:0] mem_r [DEPTH];
    // reset value comes from a constant at the instance, so it is safe here
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < DEPTH; k++) begin
                mem_r[k] <= '0;
            end
        end else if (i_we) begin
            mem_r[i_waddr] <= i_wdata;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= mem_r[i_raddr] ^ i_rst_val;
        end
    end
    always_comb begin
        for (int k = 0; k < DEPTH; k++) begin
            o_all[k*WIDTH +: WIDTH] = mem_r[k] ^ i_rst_val;
        end
    end
endmodule

// ==== hw/psrg_regs.sv ====
`timescale 1ns/100ps
// Function
// RL1: soft-start ramp length follows the selected rise-time setting
// RL2: unsupported rise-time writes snap to the nearest supported setting
// RL3: eight settings 0.6 to 9.0 ms, 2.7 ms after reset
// RL4: rise time zero jumps output straight to target, no ramp
// RL5: reference trims during soft-start slew at the rise-time rate
// RL6: rise-time register included in store-all save to memory; the code saves only the active page word, not the other page
// RL7: linear word, exponent -4 fixed, top mantissa bits zero, reset 43
// RL8: summary byte layout bits 6..0, bit 7 reads zero
// RL9: off flag set whenever converter not enabled
// RL10: output overvoltage fault sets its summary flag
// RL11: output overcurrent fault sets its summary flag
// RL12: input undervoltage fault sets its summary flag
// RL13: temperature flag on over-temperature fault or warning
// RL14: communication, memory or logic fault sets the cml flag
// RL15: other faults or warnings set the none-of-the-above flag
// RL16: summary word low byte equals summary byte
// RL17: high byte vout 7, iout 6, maker 4, power good 3
// RL18: vout flag on any output-voltage fault or warning
// RL19: iout flag only for output-current faults or warnings
// RL20: maker flag on internal overheat shutdown
// RL21: rejected write discarded, sets cml and invalid-data, raises alert
// RL22: paged registers kept per channel, selected by current page
module psrg_regs (
    input wire logic I_SYS_CLK,
    input wire logic I_SYS_RST,
    input wire logic I_PAGE,
    input wire logic I_WR,
    input wire logic I_RD,
    input wire logic [7:0] I_CMD,
    input wire logic [15:0] I_WDATA,
    output logic [15:0] O_RDATA,
    output logic O_RVALID,
    input wire logic I_STORE_ALL,
    output logic [15:0] O_NVM_RISE,
    output logic O_NVM_WE,
    input wire logic [1:0] I_ENABLE,
    input wire logic [1:0] I_VOUT_OV,
    input wire logic [1:0] I_VOUT_UV,
    input wire logic [1:0] I_IOUT_OC,
    input wire logic [1:0] I_IOUT_OCW,
    input wire logic [1:0] I_VIN_UV,
    input wire logic [1:0] I_OT_FAULT,
    input wire logic [1:0] I_OT_WARN,
    input wire logic [1:0] I_PGOOD_LOST,
    input wire logic I_OVERHEAT_SHUTDOWN,
    input wire logic I_CML_FAULT,
    input wire logic [1:0] I_CLEAR,
    input wire logic [1:0] I_START,
    input wire logic [1:0] I_REF_STEP,
    input wire logic [31:0] I_REF_TARGET,
    output logic [31:0] O_REF,
    output logic [1:0] O_RAMP_BUSY,
    output logic O_INVALID_DATA,
    output logic O_ALERT
);
    // =====================================================================
    // pin synchronisers for the analog detector levels
    // nine channel pairs plus two shared events
    localparam int NS = 20;
    logic [NS-1:0] s1_r;
    logic [NS-1:0] s2_r;
    logic [NS-1:0] raw;
    assign raw = {I_ENABLE, I_VOUT_OV, I_VOUT_UV, I_IOUT_OC, I_IOUT_OCW, I_VIN_UV,
                  I_OT_FAULT, I_OT_WARN, I_PGOOD_LOST, I_OVERHEAT_SHUTDOWN, I_CML_FAULT};
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= raw;
            s2_r <= s1_r;
        end
    end
    logic [1:0] en, vov, vuv, ioc, iocw, vuvi, otf, otw, pgl;
    logic ohs, cmlf;
    assign {en, vov, vuv, ioc, iocw, vuvi, otf, otw, pgl, ohs, cmlf} = s2_r;
    // =====================================================================
    // nearest supported rise-time setting
    function automatic logic [2:0] nearest_idx(input logic [9:0] m);
        logic [2:0] best;
        logic [9:0] d;
        logic [9:0] bd;
        best = 3'h0;
        bd = 10'h3ff;
        for (int k = 0; k < psrg_pkg::RISE_SETTINGS; k++) begin
            d = (m > {2'b00, psrg_pkg::RISE_CODE[k]}) ? m - {2'b00, psrg_pkg::RISE_CODE[k]}
                : {2'b00, psrg_pkg::RISE_CODE[k]} - m;
            if (d < bd) begin
                bd = d;
                best = k[2:0];
            end
        end
        return best;
    endfunction
    // =====================================================================
    // rise-time storage, one copy per page
    logic is_rise_wr;
    logic zero_wr;
    logic bad_wr;
    logic [9:0] wmant;
    logic [3:0] rise_wval;
    assign wmant = I_WDATA[9:0];
    assign zero_wr = (wmant == 10'h000);
    assign is_rise_wr = I_WR && (I_CMD == psrg_pkg::CMD_RISE_TIME);
    // exponent is fixed; any other exponent is data the device cannot accept
    assign bad_wr = is_rise_wr
        && (I_WDATA[15:psrg_pkg::RISE_EXP_LSB] != psrg_pkg::RISE_EXP_VAL); // see RL21
    // stored as {zero flag, index}, xor'd against reset so reset shows 2.7 ms
    assign rise_wval = zero_wr ? 4'h8 : {1'b0, nearest_idx(wmant)}; // see RL2
    logic [3:0] rise_rd;
    logic [7:0] rise_all;
    psrg_page_mem #(.WIDTH(4), .DEPTH(psrg_pkg::PAGES)) u_mem (
        .i_clk(I_SYS_CLK),
        .i_rst(I_SYS_RST),
        .i_we(is_rise_wr && !bad_wr),
        .i_waddr(I_PAGE), // see RL22
        .i_wdata(rise_wval ^ {1'b0, psrg_pkg::RISE_IDX_RST}),
        .i_raddr(I_PAGE),
        .i_rst_val({1'b0, psrg_pkg::RISE_IDX_RST}), // see RL3
        .o_rdata(rise_rd),
        .o_all(rise_all)
    );
    function automatic logic [15:0] rise_word(input logic [3:0] v);
        logic [7:0] mant;
        mant = v[3] ? 8'h00 : psrg_pkg::RISE_CODE[v[2:0]];
        return {psrg_pkg::RISE_EXP_VAL, 3'b000, mant}; // see RL7
    endfunction
    // =====================================================================
    // soft-start ramps, one per channel
    genvar g;
    generate
        for (g = 0; g < psrg_pkg::PAGES; g++) begin : gch
            psrg_ramp_if rif ();
            logic [3:0] v;
            assign v = rise_all[g*4 +: 4];
            assign rif.start = I_START[g];
            assign rif.idx = v[2:0]; // see RL1
            assign rif.instant = v[3]; // see RL4
            assign rif.target = I_REF_TARGET[g*16 +: 16];
            psrg_ramp u_ramp (
                .i_clk(I_SYS_CLK),
                .i_rst(I_SYS_RST),
                .rp(rif)
            );
            assign O_REF[g*16 +: 16] = rif.ref_val;
            assign O_RAMP_BUSY[g] = rif.busy;
        end
    endgenerate
    // =====================================================================
    // store-all snapshot of the active page rise-time word
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_NVM_RISE <= 16'h0000;
            O_NVM_WE <= 1'b0;
        end else begin
            O_NVM_WE <= I_STORE_ALL;
            if (I_STORE_ALL) begin
                O_NVM_RISE <= rise_word(rise_rd); // see RL6
            end
        end
    end
    // =====================================================================
    // sticky fault latches, set wins over clear
    logic [1:0] cml_r;
    logic [1:0] ivd_r;
    logic [7:0] lat_r [psrg_pkg::PAGES];
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            for (int p = 0; p < psrg_pkg::PAGES; p++) begin
                lat_r[p] <= 8'h00;
            end
        end else begin
            for (int p = 0; p < psrg_pkg::PAGES; p++) begin
                lat_r[p] <= (I_CLEAR[p] ? 8'h00 : lat_r[p])
                    | {ohs, pgl[p], vov[p], vuv[p], ioc[p], iocw[p], vuvi[p], otf[p] | otw[p]};
            end
        end
    end
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            cml_r <= 2'b00;
            ivd_r <= 2'b00;
        end else begin
            for (int p = 0; p < psrg_pkg::PAGES; p++) begin
                cml_r[p] <= (cml_r[p] && !I_CLEAR[p]) || cmlf
                    || (bad_wr && I_PAGE == p[0]); // see RL14
                ivd_r[p] <= (ivd_r[p] && !I_CLEAR[p]) || (bad_wr && I_PAGE == p[0]); // see RL21
            end
        end
    end
    // =====================================================================
    // summary assembly
    function automatic logic [15:0] summary(input logic [7:0] l, input logic c,
                                            input logic e);
        logic [15:0] w;
        w = 16'h0000;
        w[psrg_pkg::SB_OFF] = !e; // see RL9
        w[psrg_pkg::SB_VOUT_OV] = l[5]; // see RL10
        w[psrg_pkg::SB_IOUT_OC] = l[3]; // see RL11
        w[psrg_pkg::SB_VIN_UV] = l[1]; // see RL12
        w[psrg_pkg::SB_TEMP] = l[0]; // see RL13
        w[psrg_pkg::SB_CML] = c; // see RL14
        w[psrg_pkg::SB_OTHER] = l[4] | l[2] | l[6]; // see RL15
        w[8 + psrg_pkg::SW_VOUT] = l[5] | l[4]; // see RL18
        w[8 + psrg_pkg::SW_IOUT] = l[3] | l[2]; // see RL19
        w[8 + psrg_pkg::SW_MAKER] = l[7]; // see RL20
        w[8 + psrg_pkg::SW_PGOOD] = l[6]; // see RL17
        return w;
    endfunction
    logic [15:0] sum_w;
    assign sum_w = summary(lat_r[I_PAGE], cml_r[I_PAGE], en[I_PAGE]); // see RL22
    // =====================================================================
    // read port: answer one cycle after the request
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_RDATA <= 16'h0000;
            O_RVALID <= 1'b0;
        end else begin
            O_RVALID <= I_RD;
            if (I_RD) begin
                if (I_CMD == psrg_pkg::CMD_RISE_TIME) begin
                    O_RDATA <= rise_word(rise_rd);
                end else if (I_CMD == psrg_pkg::CMD_SUMMARY_BYTE) begin
                    O_RDATA <= {8'h00, sum_w[7:0]}; // see RL8
                end else if (I_CMD == psrg_pkg::CMD_SUMMARY_WORD) begin
                    O_RDATA <= sum_w; // see RL16
                end else begin
                    O_RDATA <= 16'h0000;
                end
            end
        end
    end
    assign O_INVALID_DATA = |ivd_r;
    always_ff @(posedge I_SYS_CLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_ALERT <= 1'b0;
        end else begin
            O_ALERT <= |ivd_r || bad_wr; // see RL21
        end
    end
    // =====================================================================
    // register-side checks

    a_bad_discard: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bad_wr |=> ##1 $stable(rise_rd) && O_ALERT) // see RL21
        else $error("rejected write changed register or missed alert");

    a_invalid_set: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        bad_wr |=> O_INVALID_DATA) // see RL21
        else $error("invalid data not flagged");

    a_byte_mirror: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_RD && I_CMD == psrg_pkg::CMD_SUMMARY_BYTE |=> O_RDATA[15:7] == 9'h000) // see RL8
        else $error("summary byte upper bits set");

    a_word_low: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_RD && I_CMD == psrg_pkg::CMD_SUMMARY_WORD |=> O_RDATA[7:0] == $past(sum_w[7:0])) // see RL16
        else $error("summary word low byte differs");

    a_word_spare: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_RD && I_CMD == psrg_pkg::CMD_SUMMARY_WORD
        |=> !O_RDATA[13] && O_RDATA[10:8] == 3'b000) // see RL17
        else $error("summary word spare bits set");

    a_rvalid_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_RD |=> O_RVALID)
        else $error("read answer missing");

    a_off_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        !en[I_PAGE] |-> sum_w[psrg_pkg::SB_OFF]) // see RL9
        else $error("off flag missing");

    a_exp_fixed: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_RD && I_CMD == psrg_pkg::CMD_RISE_TIME
        |=> O_RDATA[15:8] == {psrg_pkg::RISE_EXP_VAL, 3'b000}) // see RL7
        else $error("rise exponent or top bits wrong");

    a_ov_sticky: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        vov[0] |=> lat_r[0][5]) // see RL10
        else $error("overvoltage not latched");

    a_oc_sticky: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        ioc[0] |=> lat_r[0][3]) // see RL11
        else $error("overcurrent not latched");

    a_vin_sticky: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        vuvi[0] |=> lat_r[0][1]) // see RL12
        else $error("input undervoltage not latched");

    a_uv_sticky: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        vuv[0] |=> lat_r[0][4]) // see RL15
        else $error("output undervoltage not latched");

    a_temp_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        (otf[0] || otw[0]) |=> lat_r[0][0]) // see RL13
        else $error("temperature not latched");

    a_maker_flag: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        ohs |=> lat_r[0][7] && lat_r[1][7]) // see RL20
        else $error("overheat shutdown not latched");

    a_cml_set: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        cmlf |=> cml_r == 2'b11) // see RL14
        else $error("cml fault not latched");

    a_iout_word: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        sum_w[8 + psrg_pkg::SW_IOUT] == (lat_r[I_PAGE][3] | lat_r[I_PAGE][2])) // see RL19
        else $error("iout flag mismatch");

    a_store_rise: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_STORE_ALL |=> O_NVM_WE && O_NVM_RISE == rise_word($past(rise_rd))) // see RL6
        else $error("store-all missed rise word");

    a_nvm_pulse: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        !I_STORE_ALL |=> !O_NVM_WE) // see RL6
        else $error("store pulse without request");

    // a margin step mid-ramp must not jump the reference
    a_step_slew: assert property (@(posedge I_SYS_CLK) disable iff (I_SYS_RST)
        I_REF_STEP[0] && O_RAMP_BUSY[0] && !I_START[0]
        |=> (O_REF[15:0] - $past(O_REF[15:0]) <= 16'h0001)
            || ($past(O_REF[15:0]) - O_REF[15:0] <= 16'h0001)) // see RL5
        else $error("margin step jumped the reference");

endmodule

// ==== sim/psrg_host.sv ====
`timescale 1ns/100ps
// =====================================================================
// host model: one-cycle strobes; command and data scrambled when idle
module psrg_host (
    input wire logic i_clk,
    input wire logic [15:0] i_rdata,
    input wire logic i_rvalid,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_cmd,
    output logic [15:0] o_wdata
);
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_cmd = 8'h00;
        o_wdata = 16'h0000;
    end
    // idle edge after the strobe so a following read sees the new word
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_cmd <= c;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_cmd <= ~c;
        o_wdata <= ~d;
        @(posedge i_clk);
    endtask
    // answer is registered: valid and data sampled one cycle after the strobe
    task automatic rd(input logic [7:0] c, output logic v, output logic [15:0] q);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_cmd <= c;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_cmd <= ~c;
        #1;
        v = i_rvalid;
        q = i_rdata;
    endtask
endmodule

// ==== sim/testbench.sv ====
`timescale 1ns/100ps
module testbench;
    localparam logic [15:0] SNAP_IN [14] = '{16'he00a, 16'he00e, 16'he013, 16'he01d,
        16'he02b, 16'he043, 16'he060, 16'he090, 16'he00b, 16'he00c, 16'he011, 16'he050,
        16'he7ff, 16'he000};
    localparam logic [15:0] SNAP_EXP [14] = '{16'he00a, 16'he00e, 16'he013, 16'he01d,
        16'he02b, 16'he043, 16'he060, 16'he090, 16'he00a, 16'he00a, 16'he013, 16'he043,
        16'he090, 16'he000};
    // event order: vout_ov, vout_uv, iout_oc, iout_ocw, vin_uv, ot_fault, ot_warn,
    // pgood_lost, overheat, cml
    localparam logic [15:0] EV_EXP [10] = '{16'h8020, 16'h8001, 16'h4010, 16'h4001,
        16'h0008, 16'h0004, 16'h0004, 16'h0801, 16'h1000, 16'h0002};
    logic clk, rst, pg, wr, rd, rv, sto, nvwe, inv, alrt, alert_seen;
    logic [7:0] cmd;
    logic [15:0] wd, rdat, nvr;
    logic [1:0] en, clr, st, stp, busy;
    logic [9:0] ev;
    logic [31:0] tgt, refv;
    int n_errors = 0;
    int checks_done = 0;

    psrg_host psrg_host_i (.i_clk(clk), .i_rdata(rdat), .i_rvalid(rv), .o_wr(wr), .o_rd(rd),
        .o_cmd(cmd), .o_wdata(wd));
    psrg_regs psrg_regs_i (.I_SYS_CLK(clk), .I_SYS_RST(rst), .I_PAGE(pg), .I_WR(wr),
        .I_RD(rd), .I_CMD(cmd), .I_WDATA(wd), .O_RDATA(rdat), .O_RVALID(rv),
        .I_STORE_ALL(sto), .O_NVM_RISE(nvr), .O_NVM_WE(nvwe), .I_ENABLE(en),
        .I_VOUT_OV({1'b0, ev[0]}), .I_VOUT_UV({1'b0, ev[1]}), .I_IOUT_OC({1'b0, ev[2]}),
        .I_IOUT_OCW({1'b0, ev[3]}), .I_VIN_UV({1'b0, ev[4]}), .I_OT_FAULT({1'b0, ev[5]}),
        .I_OT_WARN({1'b0, ev[6]}), .I_PGOOD_LOST({1'b0, ev[7]}),
        .I_OVERHEAT_SHUTDOWN(ev[8]), .I_CML_FAULT(ev[9]), .I_CLEAR(clr), .I_START(st),
        .I_REF_STEP(stp), .I_REF_TARGET(tgt), .O_REF(refv), .O_RAMP_BUSY(busy),
        .O_INVALID_DATA(inv), .O_ALERT(alrt));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // alert may be a pulse, so it is caught here
    always @(posedge clk) if (alrt === 1'b1) alert_seen <= 1'b1;

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] c, input logic [15:0] e);
        logic v;
        logic [15:0] q;
        psrg_host_i.rd(c, v, q);
        chk({nm, " valid"}, 16'h0001, {15'h0000, v});
        chk(nm, e, q);
    endtask
    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end

    initial begin
        {rst, pg, sto, alert_seen} = 4'h8;
        {en, clr, st, stp, ev, tgt} = '0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        en <= 2'b11;
        // =============================================================
        // reset word on both pages, then nearest-setting snapping
        for (int p = 0; p < 2; p++) begin
            @(posedge clk) pg <= p[0];
            rd_chk("rise reset", psrg_pkg::CMD_RISE_TIME, 16'he02b);
        end
        @(posedge clk) pg <= 1'b0;
        for (int i = 0; i < 14; i++) begin
            psrg_host_i.wr(psrg_pkg::CMD_RISE_TIME, SNAP_IN[i]);
            rd_chk("rise snap", psrg_pkg::CMD_RISE_TIME, SNAP_EXP[i]);
        end
        rd_chk("unmapped", 8'h62, 16'h0000);
        // =============================================================
        // ramp: page 0 fastest setting, page 1 instant
        psrg_host_i.wr(psrg_pkg::CMD_RISE_TIME, 16'he00a);
        @(posedge clk) pg <= 1'b1;
        psrg_host_i.wr(psrg_pkg::CMD_RISE_TIME, 16'he000);
        rd_chk("page 1 rise", psrg_pkg::CMD_RISE_TIME, 16'he000);
        @(posedge clk) pg <= 1'b0;
        rd_chk("page 0 rise", psrg_pkg::CMD_RISE_TIME, 16'he00a);
        @(posedge clk) begin
            tgt <= 32'h1234_0100;
            st <= 2'b11;
        end
        @(posedge clk) st <= 2'b00;
        repeat (6) @(posedge clk);
        chk("instant ref", 16'h1234, refv[31:16]);
        repeat (44) @(posedge clk);
        chk("ramp early", 16'h0001, {15'h0000, busy[0] && refv[15:0] < 16'h0100});
        @(posedge clk) begin
            tgt[15:0] <= 16'h0200;
            stp <= 2'b01;
        end
        @(posedge clk) stp <= 2'b00;
        // one step per cycle, so the trimmed target is still far off here
        repeat (300) @(posedge clk);
        chk("trim slew", 16'h0001, {15'h0000, busy[0] && refv[15:0] < 16'h0200});
        repeat (300) @(posedge clk);
        chk("ramp end", 16'h0200, refv[15:0]);
        chk("ramp idle", 16'h0000, {14'h0000, busy});
        // =============================================================
        // store-all hands over the active page word
        @(posedge clk) sto <= 1'b1;
        @(posedge clk) sto <= 1'b0;
        #1;
        chk("nvm we", 16'h0001, {15'h0000, nvwe});
        chk("nvm word", 16'he00a, nvr);
        // =============================================================
        // summary flags, one event at a time, latched until cleared
        for (int k = 0; k < 10; k++) begin
            @(posedge clk) ev <= 10'h001 << k;
            repeat (6) @(posedge clk);
            @(posedge clk) pg <= 1'b0;
            rd_chk("byte", psrg_pkg::CMD_SUMMARY_BYTE, {8'h00, EV_EXP[k][7:0]});
            @(posedge clk) ev <= 10'h000;
            repeat (4) @(posedge clk);
            rd_chk("word", psrg_pkg::CMD_SUMMARY_WORD, EV_EXP[k]);
            @(posedge clk) pg <= 1'b1;
            rd_chk("word p1", psrg_pkg::CMD_SUMMARY_WORD, (k < 8) ? 16'h0000 : EV_EXP[k]);
            @(posedge clk) clr <= 2'b11;
            @(posedge clk) clr <= 2'b00;
            repeat (2) @(posedge clk);
        end
        // =============================================================
        // converter off, then a refused rise write
        @(posedge clk) begin
            en <= 2'b10;
            pg <= 1'b0;
        end
        repeat (6) @(posedge clk);
        rd_chk("off", psrg_pkg::CMD_SUMMARY_BYTE, 16'h0040);
        @(posedge clk) en <= 2'b11;
        repeat (6) @(posedge clk);
        psrg_host_i.wr(psrg_pkg::CMD_RISE_TIME, 16'h0013);
        rd_chk("refused", psrg_pkg::CMD_RISE_TIME, 16'he00a);
        rd_chk("cml", psrg_pkg::CMD_SUMMARY_WORD, 16'h0002);
        chk("invalid", 16'h0001, {15'h0000, inv});
        chk("alert", 16'h0001, {15'h0000, alert_seen});
        @(posedge clk) pg <= 1'b1;
        rd_chk("cml p1", psrg_pkg::CMD_SUMMARY_WORD, 16'h0000);
        print_verdict();
    end
endmodule
